// File: ucbg_usart.sv
// serial transceiver with baud generator, four clock modes, tx and rx paths
// assumes config ports come from logic on clk; pins are asynchronous to clk
`include "ucbg_cfg.svh"
`default_nettype none

module ucbg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             inValid,
  output var  logic             inReady,
  input  wire logic [WIDTH-1:0] inData,
  output var  logic             outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  wire              push = inValid && inReady;
  wire              pop  = outValid && outReady;

  assign count_next = count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
  assign outData    = mem[rdPtr_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // ready and valid are registered so both edges of the fifo are clean flops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      inReady   <= 1'b0;
      outValid  <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == LAST) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == LAST) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_next;
      inReady   <= (count_next != FULL);
      outValid  <= (count_next != '0);
    end
  end
endmodule

module ucbg_usart #(
  parameter int TX_FIFO_DEPTH = `UCBG_TX_FIFO_DEPTH
) (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        syncModeSelect,
  input  wire logic                        doubleSpeedSelect,
  input  wire logic                        transferClockPinDirection,
  input  wire logic                        syncClockPolarity,
  input  wire logic [`UCBG_DIV_W-9:0]      baudDivisorHigh,
  input  wire logic [7:0]                  baudDivisorLow,
  input  wire logic                        baudDivisorLowWrite,
  input  wire logic [`UCBG_SIZE_W-1:0]     charSize,
  input  wire logic [1:0]                  parityMode,
  input  wire logic                        twoStopBits,
  input  wire logic                        txEnable,
  input  wire logic                        rxEnable,
  input  wire logic [`UCBG_DATA_W-1:0]     txData,
  input  wire logic                        txValid,
  output var  logic                        txReady,
  output var  ucbg_pkg::ucbg_rx_word_t     rxWord,
  output var  logic                        rxValid,
  input  wire logic                        rxReady,
  output var  logic                        rxOverrun,
  output var  logic                        txCompleteEvent,
  output var  logic                        txBufferEmpty,
  output var  logic                        rxComplete,
  input  wire logic                        serialInPin,
  output var  logic                        serialOutPin,
  input  wire logic                        transferClockPinIn,
  output var  logic                        transferClockPinOut,
  output var  logic                        transferClockPinOe
);
  // ---- mode decode
  ucbg_pkg::ucbg_mode_t   mode;
  ucbg_pkg::ucbg_parity_t parity;
  wire asyncMode = !syncModeSelect;
  wire isMaster  = (mode == ucbg_pkg::UCBG_SYNC_MASTER);
  wire isSlave   = (mode == ucbg_pkg::UCBG_SYNC_SLAVE);
  wire isDouble  = (mode == ucbg_pkg::UCBG_ASYNC_DOUBLE);

  assign mode = asyncMode ? (doubleSpeedSelect ? ucbg_pkg::UCBG_ASYNC_DOUBLE
                                               : ucbg_pkg::UCBG_ASYNC_NORMAL)
                          : (transferClockPinDirection ? ucbg_pkg::UCBG_SYNC_MASTER
                                                       : ucbg_pkg::UCBG_SYNC_SLAVE);
  assign parity = ucbg_pkg::ucbg_parity_t'(parityMode);

  wire [`UCBG_PHASE_W-1:0] phaseLast = isDouble ? `UCBG_PHASE_LAST_D : `UCBG_PHASE_LAST_N;
  wire [`UCBG_PHASE_W-1:0] phaseMid  = isDouble ? `UCBG_PHASE_MID_D : `UCBG_PHASE_MID_N;
  wire [3:0]               dataBits  = 4'(charSize) + `UCBG_SIZE_OFFSET;
  wire [3:0]               lastBit   = dataBits - 4'h1;

  // ---- baud generator
  logic [`UCBG_DIV_W-1:0] baudCnt_reg;
  wire  [`UCBG_DIV_W-1:0] divisor  = {baudDivisorHigh, baudDivisorLow};
  wire                    baudTick = (baudCnt_reg == '0);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      baudCnt_reg <= `UCBG_DIV_RESET;
    end else if (baudDivisorLowWrite || baudTick) begin
      baudCnt_reg <= divisor;
    end else begin
      baudCnt_reg <= baudCnt_reg - 1'b1;
    end
  end

  // ---- pin synchronisers; the first stage feeds only the second
  logic rxMeta_reg;
  logic rxSync_reg;
  logic xckMeta_reg;
  logic xckSync_reg;
  logic xckDly_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxMeta_reg  <= 1'b1;
      rxSync_reg  <= 1'b1;
      xckMeta_reg <= 1'b0;
      xckSync_reg <= 1'b0;
      xckDly_reg  <= 1'b0;
    end else begin
      rxMeta_reg  <= serialInPin;
      rxSync_reg  <= rxMeta_reg;
      xckMeta_reg <= transferClockPinIn;
      xckSync_reg <= xckMeta_reg;
      xckDly_reg  <= xckSync_reg;
    end
  end

  // ---- transfer clock: master toggles on baud ticks, slave edges detected
  // slave edges lag the pin by two clocks, so the far clock must stay under clk/4
  logic xck_reg;
  wire  slaveRise  = isSlave && xckSync_reg && !xckDly_reg;
  wire  slaveFall  = isSlave && !xckSync_reg && xckDly_reg;
  wire  masterRise = isMaster && baudTick && !xck_reg;
  wire  masterFall = isMaster && baudTick && xck_reg;
  wire  syncRise   = masterRise || slaveRise;
  wire  syncFall   = masterFall || slaveFall;
  wire  txEdge     = syncClockPolarity ? syncFall : syncRise;
  wire  rxEdge     = syncClockPolarity ? syncRise : syncFall;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      xck_reg             <= 1'b0;
      transferClockPinOut <= 1'b0;
      transferClockPinOe  <= 1'b0;
    end else begin
      xck_reg             <= isMaster ? (xck_reg ^ baudTick) : 1'b0;
      transferClockPinOut <= isMaster ? (xck_reg ^ baudTick) : 1'b0;
      transferClockPinOe  <= isMaster;
    end
  end

  // ---- transmit path: fifo, single write buffer, shifter
  logic [`UCBG_DATA_W-1:0] txFifoData;
  logic                    txFifoValid;
  logic [`UCBG_DATA_W-1:0] txBuf_reg;
  logic                    txBufFull_reg;
  logic                    txBufFull_next;
  logic [`UCBG_DATA_W-1:0] txShift_reg;
  logic [3:0]              txCnt_reg;
  logic                    txPar_reg;
  logic                    txStop2_reg;
  logic [`UCBG_PHASE_W-1:0] txDiv_reg;
  ucbg_pkg::ucbg_tx_state_t txState_reg;

  ucbg_fifo #(
    .WIDTH (`UCBG_DATA_W),
    .DEPTH (TX_FIFO_DEPTH)
  ) txFifo (
    .clk      (clk),
    .rst_b    (rst_b),
    .inValid  (txValid),
    .inReady  (txReady),
    .inData   (txData),
    .outValid (txFifoValid),
    .outReady (!txBufFull_reg),
    .outData  (txFifoData)
  );

  wire txBufLoad = txFifoValid && !txBufFull_reg;
  // async bit clock is baud tick over 16 or 8; sync uses the change edge
  wire txBitTick = asyncMode ? (baudTick && txDiv_reg == phaseLast) : txEdge;
  wire txFrameEnd = (txState_reg == ucbg_pkg::UCBG_TX_STOP) && txBitTick
                    && !(twoStopBits && !txStop2_reg);
  wire txStartNew = txBitTick && txBufFull_reg && txEnable
                    && ((txState_reg == ucbg_pkg::UCBG_TX_IDLE) || txFrameEnd);
  assign txBufFull_next = txBufLoad ? 1'b1 : (txStartNew ? 1'b0 : txBufFull_reg);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txDiv_reg <= `UCBG_PHASE_ZERO;
    end else if (!asyncMode || txDiv_reg > phaseLast) begin
      txDiv_reg <= `UCBG_PHASE_ZERO;
    end else if (baudTick) begin
      txDiv_reg <= (txDiv_reg == phaseLast) ? `UCBG_PHASE_ZERO : txDiv_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txBuf_reg     <= '0;
      txBufFull_reg <= 1'b0;
      txBufferEmpty <= 1'b0;
    end else begin
      if (txBufLoad) begin
        txBuf_reg <= txFifoData;
      end
      txBufFull_reg <= txBufFull_next;
      txBufferEmpty <= !txBufFull_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txState_reg     <= ucbg_pkg::UCBG_TX_IDLE;
      txShift_reg     <= '0;
      txCnt_reg       <= 4'h0;
      txPar_reg       <= 1'b0;
      txStop2_reg     <= 1'b0;
      serialOutPin    <= 1'b1;
      txCompleteEvent <= 1'b0;
    end else begin
      txCompleteEvent <= 1'b0;
      if (txStartNew) begin
        // back-to-back: a waiting character starts right after the stop bit
        txState_reg  <= ucbg_pkg::UCBG_TX_START;
        txShift_reg  <= txBuf_reg;
        serialOutPin <= 1'b0;
      end else if (txBitTick) begin
        unique case (txState_reg)
          ucbg_pkg::UCBG_TX_IDLE: begin
            serialOutPin <= 1'b1;
          end
          ucbg_pkg::UCBG_TX_START: begin
            serialOutPin <= txShift_reg[0];
            txPar_reg    <= txShift_reg[0];
            txShift_reg  <= txShift_reg >> 1;
            txCnt_reg    <= 4'h0;
            txState_reg  <= ucbg_pkg::UCBG_TX_DATA;
          end
          ucbg_pkg::UCBG_TX_DATA: begin
            if (txCnt_reg == lastBit) begin
              txStop2_reg <= 1'b0;
              if (parity.enable) begin
                serialOutPin <= txPar_reg ^ parity.odd;
                txState_reg  <= ucbg_pkg::UCBG_TX_PARITY;
              end else begin
                serialOutPin <= 1'b1;
                txState_reg  <= ucbg_pkg::UCBG_TX_STOP;
              end
            end else begin
              serialOutPin <= txShift_reg[0];
              txPar_reg    <= txPar_reg ^ txShift_reg[0];
              txShift_reg  <= txShift_reg >> 1;
              txCnt_reg    <= txCnt_reg + 4'h1;
            end
          end
          ucbg_pkg::UCBG_TX_PARITY: begin
            serialOutPin <= 1'b1;
            txState_reg  <= ucbg_pkg::UCBG_TX_STOP;
          end
          ucbg_pkg::UCBG_TX_STOP: begin
            if (twoStopBits && !txStop2_reg) begin
              txStop2_reg <= 1'b1;
            end else begin
              serialOutPin    <= 1'b1;
              txState_reg     <= ucbg_pkg::UCBG_TX_IDLE;
              txCompleteEvent <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ---- receive path: recovery, shifter, two-entry buffer
  logic [2:0]               rxHist_reg;
  logic [`UCBG_PHASE_W-1:0] rxPhase_reg;
  logic [`UCBG_DATA_W-1:0]  rxShift_reg;
  logic [3:0]               rxCnt_reg;
  logic                     rxPar_reg;
  logic                     rxParErr_reg;
  logic                     rxInReady;
  ucbg_pkg::ucbg_rx_state_t rxState_reg;
  ucbg_pkg::ucbg_rx_word_t  rxPushWord;

  // three samples around mid-bit voted, a cheap low-pass against glitches
  wire [2:0] rxHistNext = {rxHist_reg[1:0], rxSync_reg};
  wire       rxVote     = (rxHistNext[0] & rxHistNext[1]) | (rxHistNext[1] & rxHistNext[2])
                          | (rxHistNext[0] & rxHistNext[2]);
  wire       rxStrobe   = asyncMode ? (baudTick && rxPhase_reg == phaseMid) : rxEdge;
  wire       rxBit      = asyncMode ? rxVote : rxSync_reg;
  wire       rxStartDet = (asyncMode ? baudTick : rxEdge) && !rxSync_reg;
  wire       rxPush     = (rxState_reg == ucbg_pkg::UCBG_RX_STOP) && rxStrobe;
  wire [3:0] rxAlign    = 4'(`UCBG_DATA_W) - dataBits;

  assign rxPushWord.data      = rxShift_reg >> rxAlign;
  assign rxPushWord.frameErr  = !rxBit;
  assign rxPushWord.parityErr = rxParErr_reg;

  ucbg_fifo #(
    .WIDTH ($bits(ucbg_pkg::ucbg_rx_word_t)),
    .DEPTH (`UCBG_RX_BUF_DEPTH)
  ) rxBuf (
    .clk      (clk),
    .rst_b    (rst_b),
    .inValid  (rxPush),
    .inReady  (rxInReady),
    .inData   (rxPushWord),
    .outValid (rxValid),
    .outReady (rxReady),
    .outData  (rxWord)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxOverrun  <= 1'b0;
      rxComplete <= 1'b0;
    end else begin
      // a drop in the same cycle as a read keeps the flag set
      rxOverrun  <= (rxPush && !rxInReady) || (rxOverrun && !(rxValid && rxReady));
      rxComplete <= rxValid;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxHist_reg  <= 3'h7;
      rxPhase_reg <= `UCBG_PHASE_ZERO;
    end else begin
      if (baudTick) begin
        rxHist_reg <= rxHistNext;
      end
      if (rxState_reg == ucbg_pkg::UCBG_RX_IDLE) begin
        rxPhase_reg <= `UCBG_PHASE_FIRST;
      end else if (baudTick) begin
        rxPhase_reg <= (rxPhase_reg >= phaseLast) ? `UCBG_PHASE_ZERO : rxPhase_reg + 1'b1;
      end
    end
  end

  // independent of the transmit state machine, so both directions run at once
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxState_reg  <= ucbg_pkg::UCBG_RX_IDLE;
      rxShift_reg  <= '0;
      rxCnt_reg    <= 4'h0;
      rxPar_reg    <= 1'b0;
      rxParErr_reg <= 1'b0;
    end else if (!rxEnable) begin
      rxState_reg <= ucbg_pkg::UCBG_RX_IDLE;
    end else begin
      unique case (rxState_reg)
        ucbg_pkg::UCBG_RX_IDLE: begin
          if (rxStartDet) begin
            rxCnt_reg    <= 4'h0;
            rxPar_reg    <= 1'b0;
            rxParErr_reg <= 1'b0;
            rxState_reg  <= asyncMode ? ucbg_pkg::UCBG_RX_START : ucbg_pkg::UCBG_RX_DATA;
          end
        end
        ucbg_pkg::UCBG_RX_START: begin
          if (rxStrobe) begin
            rxState_reg <= rxBit ? ucbg_pkg::UCBG_RX_IDLE : ucbg_pkg::UCBG_RX_DATA;
          end
        end
        ucbg_pkg::UCBG_RX_DATA: begin
          if (rxStrobe) begin
            rxShift_reg <= {rxBit, rxShift_reg[`UCBG_DATA_W-1:1]};
            rxPar_reg   <= rxPar_reg ^ rxBit;
            rxCnt_reg   <= rxCnt_reg + 4'h1;
            if (rxCnt_reg == lastBit) begin
              rxState_reg <= parity.enable ? ucbg_pkg::UCBG_RX_PARITY : ucbg_pkg::UCBG_RX_STOP;
            end
          end
        end
        ucbg_pkg::UCBG_RX_PARITY: begin
          if (rxStrobe) begin
            rxParErr_reg <= rxPar_reg ^ rxBit ^ parity.odd;
            rxState_reg  <= ucbg_pkg::UCBG_RX_STOP;
          end
        end
        ucbg_pkg::UCBG_RX_STOP: begin
          // second stop bit is not checked; the line returns to idle hunting
          if (rxStrobe) begin
            rxState_reg <= ucbg_pkg::UCBG_RX_IDLE;
          end
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// File: ucbg_cfg.svh
// constants for the serial transceiver: widths, phases and field encodings
// assumes a single system clock; included by the package and the design file
`ifndef UCBG_CFG_SVH
`define UCBG_CFG_SVH

`define UCBG_DIV_W          12
`define UCBG_DIV_RESET      12'h000
`define UCBG_DATA_W         9
`define UCBG_SIZE_W         3
`define UCBG_SIZE_OFFSET    4'h5
`define UCBG_PHASE_W        4
`define UCBG_PHASE_LAST_N   4'hF
`define UCBG_PHASE_LAST_D   4'h7
`define UCBG_PHASE_MID_N    4'h9
`define UCBG_PHASE_MID_D    4'h5
`define UCBG_PHASE_FIRST    4'h1
`define UCBG_PHASE_ZERO     4'h0
`define UCBG_TX_FIFO_DEPTH  16
`define UCBG_RX_BUF_DEPTH   2

`endif

// File: ucbg_pkg.sv
// shared types of the serial transceiver
// assumes ucbg_cfg.svh sits in the include path
`include "ucbg_cfg.svh"
`default_nettype none

package ucbg_pkg;

  typedef enum logic [1:0] {
    UCBG_ASYNC_NORMAL,
    UCBG_ASYNC_DOUBLE,
    UCBG_SYNC_MASTER,
    UCBG_SYNC_SLAVE
  } ucbg_mode_t;

  // parityMode input encoding: bit 1 enables, bit 0 selects odd
  typedef struct packed {
    logic enable;
    logic odd;
  } ucbg_parity_t;

  typedef enum logic [2:0] {
    UCBG_RX_IDLE,
    UCBG_RX_START,
    UCBG_RX_DATA,
    UCBG_RX_PARITY,
    UCBG_RX_STOP
  } ucbg_rx_state_t;

  typedef enum logic [2:0] {
    UCBG_TX_IDLE,
    UCBG_TX_START,
    UCBG_TX_DATA,
    UCBG_TX_PARITY,
    UCBG_TX_STOP
  } ucbg_tx_state_t;

  typedef struct packed {
    logic [`UCBG_DATA_W-1:0] data;
    logic                    frameErr;
    logic                    parityErr;
  } ucbg_rx_word_t;

endpackage

`default_nettype wire

// File: ucbg_usart_props.sv
// concurrent checks on the serial transceiver ports
// assumes one clock domain with a synchronous active-low reset
`include "ucbg_cfg.svh"
`default_nettype none
module ucbg_usart_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic syncModeSelect,
  input wire logic transferClockPinDirection,
  input wire logic [`UCBG_DIV_W-9:0] baudDivisorHigh,
  input wire logic [7:0] baudDivisorLow,
  input wire logic baudDivisorLowWrite,
  input wire logic txValid,
  input wire logic txReady,
  input wire ucbg_pkg::ucbg_rx_word_t rxWord,
  input wire logic rxValid,
  input wire logic rxReady,
  input wire logic rxOverrun,
  input wire logic txCompleteEvent,
  input wire logic txBufferEmpty,
  input wire logic rxComplete,
  input wire logic serialOutPin,
  input wire logic transferClockPinOut,
  input wire logic transferClockPinOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic [12:0] gapCnt;
  logic armed;
  logic lastOut;
  wire logic xckFlip = lastOut != transferClockPinOut;
  wire logic [12:0] period = {1'b0, baudDivisorHigh, baudDivisorLow} + 13'h1;
  // gap is trusted only after one flip with no reload since
  always_ff @(posedge clk) begin
    lastOut <= transferClockPinOut;
    gapCnt <= xckFlip ? 13'h1 : gapCnt + 13'h1;
    armed <= rst_b && transferClockPinOe && !baudDivisorLowWrite && (armed || xckFlip);
  end
  sequence txPush;
    txValid && txReady && txBufferEmpty;
  endsequence
  sequence rxHeld;
    rxValid && !rxReady;
  endsequence
  rest_state_a: assert property (disable iff (1'b0) !rst_b |=> serialOutPin && !rxValid && !transferClockPinOe)
    else $error("outputs not at rest in reset");
  ready_rise_a: assert property ($rose(rst_b) |=> txReady)
    else $error("tx not ready after reset");
  oe_master_a: assert property (transferClockPinOe |-> $past(syncModeSelect && transferClockPinDirection))
    else $error("clock pin driven outside master mode");
  oe_async_a: assert property (!syncModeSelect [*2] |-> !transferClockPinOe)
    else $error("clock pin driven in async mode");
  xck_period_a: assert property (xckFlip && armed && transferClockPinOe |-> gapCnt == period)
    else $error("master clock half period wrong");
  tx_pulse_a: assert property (txCompleteEvent |=> !txCompleteEvent)
    else $error("tx complete longer than one cycle");
  rx_flag_a: assert property (1'b1 |=> rxComplete == $past(rxValid))
    else $error("rx complete does not track valid");
  overrun_full_a: assert property ($rose(rxOverrun) |-> $past(rxValid))
    else $error("overrun with free buffer");
  rx_hold_a: assert property (rxHeld |=> rxValid && $stable(rxWord))
    else $error("unread rx word changed");
  buf_fill_a: assert property (txPush |-> ##[1:4] !txBufferEmpty)
    else $error("write buffer never filled");
endmodule
bind ucbg_usart ucbg_usart_props i_props (.clk, .rst_b, .syncModeSelect,
  .transferClockPinDirection, .baudDivisorHigh, .baudDivisorLow, .baudDivisorLowWrite,
  .txValid, .txReady, .rxWord, .rxValid, .rxReady, .rxOverrun, .txCompleteEvent,
  .txBufferEmpty, .rxComplete, .serialOutPin, .transferClockPinOut, .transferClockPinOe);
`default_nettype wire

// File: ucbg_remote.sv
// far serial end: sends frames to the receiver, collects frames from the transmitter
// assumes async framing at bitTime clocks per bit, lsb first
`default_nettype none
module ucbg_remote (
  input wire logic clk,
  input wire logic [15:0] bitTime,
  input wire logic [3:0] nBits,
  input wire logic parEn,
  input wire logic txLine,
  output var logic rxLine
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] gotQ[$];
  logic [9:0] word;
  initial rxLine = 1'b1;
  task automatic hold(input logic v);
    rxLine = v;
    repeat (bitTime) @(posedge clk);
    #1;
  endtask
  // start, data lsb first, optional parity, one stop; line idles high
  task automatic sendFrame(input logic [9:0] bits, input int n, input logic badStop);
    hold(1'b0);
    for (int i = 0; i < n; i++) hold(bits[i]);
    hold(!badStop);
    if (badStop) hold(1'b1);
  endtask
  // samples mid-bit, so a wrong bit rate shows as wrong data
  always begin
    @(negedge txLine);
    word = 10'h000;
    repeat (bitTime / 2) @(posedge clk);
    for (int i = 0; i < nBits + parEn; i++) begin
      repeat (bitTime) @(posedge clk);
      word[i] = txLine;
    end
    gotQ.push_back(word);
    repeat (bitTime) @(posedge clk);
  end
endmodule
`default_nettype wire

// File: ucbg_usart_test.sv
// self-checking bench for ucbg_usart: framing both ways, rates, errors, fill, master clock
// assumes ucbg_remote as far end and ucbg_usart_props bound to the design
`default_nettype none
module ucbg_usart_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, syncModeSelect = 1'b0, doubleSpeedSelect = 1'b0;
  logic transferClockPinDirection = 1'b0, syncClockPolarity = 1'b0, baudDivisorLowWrite = 1'b0;
  logic twoStopBits = 1'b0, txEnable = 1'b1, rxEnable = 1'b1, txValid = 1'b0, rxReady = 1'b0;
  logic transferClockPinIn = 1'b0, sawFull = 1'b0, serialInPin, txReady, rxValid, rxOverrun;
  logic txCompleteEvent, txBufferEmpty, rxComplete, serialOutPin, transferClockPinOut;
  logic transferClockPinOe;
  logic [3:0] baudDivisorHigh = 4'h0;
  logic [7:0] baudDivisorLow = 8'h00;
  logic [2:0] charSize = 3'h3;
  logic [1:0] parityMode = 2'h0;
  logic [8:0] txData = 9'h000, d0;
  logic [9:0] expQ[$];
  logic [9:0] slaveWord = 10'h000;
  ucbg_pkg::ucbg_rx_word_t rxWord;
  int error_cnt = 0, check_count = 0, cycles = 0, seed = 32'h423cd715;
  wire logic [3:0] nBits = {1'b0, charSize} + 4'h5;
  wire logic [15:0] bitTime = (doubleSpeedSelect ? 16'h8 : 16'h10)
    * ({4'h0, baudDivisorHigh, baudDivisorLow} + 16'h1);
  ucbg_usart i_dut (.clk, .rst_b, .syncModeSelect, .doubleSpeedSelect, .transferClockPinDirection,
    .syncClockPolarity, .baudDivisorHigh, .baudDivisorLow, .baudDivisorLowWrite, .charSize,
    .parityMode, .twoStopBits, .txEnable, .rxEnable, .txData, .txValid, .txReady, .rxWord,
    .rxValid, .rxReady, .rxOverrun, .txCompleteEvent, .txBufferEmpty, .rxComplete, .serialInPin,
    .serialOutPin, .transferClockPinIn, .transferClockPinOut, .transferClockPinOe);
  ucbg_remote i_far (.clk, .bitTime, .nBits, .parEn(parityMode[1]), .txLine(serialOutPin),
    .rxLine(serialInPin));
  always #4 clk = ~clk;
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // frame bits as the wire carries them, parity bit just above the data
  function automatic logic [9:0] frame(input logic [8:0] d, input logic flip);
    logic [9:0] f;
    f = {1'b0, d} & ((10'h1 << nBits) - 10'h1);
    if (parityMode[1]) f[nBits] = ^f ^ parityMode[0] ^ flip;
    return f;
  endfunction
  task automatic setDiv(input logic [11:0] v);
    {baudDivisorHigh, baudDivisorLow} = v;
    baudDivisorLowWrite = 1'b1;
    tick(1);
    baudDivisorLowWrite = 1'b0;
  endtask
  // leaves valid high so back-to-back pushes need no idle cycle
  task automatic push(input logic [8:0] d);
    while (txReady !== 1'b1) begin
      sawFull = 1'b1;
      tick(1);
    end
    txData = d;
    txValid = 1'b1;
    expQ.push_back(frame(d, 1'b0));
    tick(1);
  endtask
  task automatic drain;
    int n = 0;
    while (i_far.gotQ.size() < expQ.size() && n < 30000) begin
      tick(1);
      n++;
    end
    // let parity and stop bits end so a settings change cannot cut a frame
    tick(3 * bitTime);
    while (expQ.size() > 0) check(i_far.gotQ.pop_front(), expQ.pop_front());
  endtask
  task automatic expectRx(input logic [8:0] d, input logic [1:0] errs);
    int n = 0;
    while (rxValid !== 1'b1 && n < 9000) begin
      tick(1);
      n++;
    end
    check({1'b0, rxWord.data}, frame(d, 1'b0) & ~(10'h1 << nBits));
    check({8'h0, rxWord.frameErr, rxWord.parityErr}, {8'h0, errs});
    rxReady = 1'b1;
    tick(1);
    rxReady = 1'b0;
  endtask
  initial begin
    tick(3);
    rst_b = 1'b1;
    tick(2);
    for (int m = 0; m < 10; m++) begin
      doubleSpeedSelect = m[0];
      charSize = 3'(m / 2);
      parityMode = 2'($random(seed));
      twoStopBits = 1'($random(seed));
      setDiv({4'h0, 8'($random(seed)) & 8'h03});
      d0 = 9'($random(seed));
      fork
        begin
          push(9'($random(seed)));
          push(d0);
          txValid = 1'b0;
        end
        i_far.sendFrame(frame(d0, 1'b0), nBits + parityMode[1], 1'b0);
      join
      expectRx(d0, 2'b00);
      drain();
    end
    parityMode = 2'h2;
    i_far.sendFrame(frame(d0, 1'b1), 10, 1'b0);
    expectRx(d0, 2'b01);
    i_far.sendFrame(frame(d0, 1'b0), 10, 1'b1);
    expectRx(d0, 2'b10);
    for (int k = 0; k < 3; k++) i_far.sendFrame(frame(9'(k), 1'b0), 10, 1'b0);
    check({9'h0, rxOverrun}, 10'h1);
    expectRx(9'h000, 2'b00);
    check({9'h0, rxOverrun}, 10'h0);
    expectRx(9'h001, 2'b00);
    i_far.rxLine = 1'b0;
    tick(2);
    i_far.rxLine = 1'b1;
    tick(200);
    check({9'h0, rxValid}, 10'h0);
    for (int k = 0; k < 20; k++) push(9'($random(seed)));
    txValid = 1'b0;
    check({9'h0, sawFull}, 10'h1);
    drain();
    doubleSpeedSelect = 1'b0;
    syncModeSelect = 1'b1;
    transferClockPinDirection = 1'b1;
    setDiv(12'hFFF);
    tick(9000);
    check({9'h0, transferClockPinOe}, 10'h1);
    syncModeSelect = 1'b0;
    tick(2);
    check({9'h0, transferClockPinOe}, 10'h0);
    // slave: far clock at clk/16 stays well under the clk/4 limit
    transferClockPinDirection = 1'b0;
    syncModeSelect = 1'b1;
    push(d0);
    txValid = 1'b0;
    tick(4);
    for (int k = 0; k < 11; k++) begin
      transferClockPinIn = 1'b1;
      tick(8);
      transferClockPinIn = 1'b0;
      tick(8);
      slaveWord = {serialOutPin, slaveWord[9:1]};
    end
    check(slaveWord, expQ.pop_front());
    finish_test();
  end
endmodule
`default_nettype wire
